// ==== verilog/rtcia_pkg.sv ====
// Purpose: shared constants for the clock interval timer, alarm and calibration output
// Assumes: 20 MHz reference clock, 8-bit special function register data
// Notes:   indirect register indexes are the pointer values software loads
package rtcia_pkg;

   // reference clock
   localparam int unsigned CLK_HZ         = 20_000_000;

   // indirect register indexes (pointer bits [4:0])
   localparam logic [4:0]  IDX_INTERVAL   = 5'h09;
   localparam logic [4:0]  IDX_AL_SECOND  = 5'h0A;
   localparam logic [4:0]  IDX_AL_MINUTE  = 5'h0B;
   localparam logic [4:0]  IDX_ALARM_HOUR_VALUE    = 5'h0C;
   localparam logic [4:0]  IDX_AL_WEEKDAY = 5'h0D;
   localparam logic [4:0]  IDX_ALARM_DATE_VALUE    = 5'h0E;
   localparam logic [4:0]  IDX_CAL_CFG    = 5'h0F;

   // reset values
   localparam logic [7:0]  RST_BYTE       = 8'h00;
   localparam logic [4:0]  RST_PTR        = 5'h00;

   // write key
   localparam logic [7:0]  KEY_VALUE      = 8'hEA;

   // pointer port fields
   localparam int unsigned PTR_WRITE_BIT  = 7;
   localparam int unsigned PTR_ADDR_MSB   = 4;

   // clock_config_one fields
   localparam int unsigned C1_ALARM_HIT   = 6;
   localparam int unsigned C1_BASE_MSB    = 5;
   localparam int unsigned C1_BASE_LSB    = 4;
   localparam int unsigned C1_SINGLE_SHOT = 3;
   localparam int unsigned C1_INT_HIT     = 2;
   localparam int unsigned C1_INT_ENABLE  = 1;

   // clock_config_two alarm field enables
   localparam int unsigned C2_SEC_ON      = 0;
   localparam int unsigned C2_MIN_ON      = 1;
   localparam int unsigned C2_HOUR_ON     = 2;
   localparam int unsigned C2_WDAY_ON     = 3;
   localparam int unsigned C2_DATE_ON     = 4;

   // cal_output_config fields
   localparam int unsigned CAL_DEEP_KEEP  = 7;
   localparam int unsigned CAL_GATE       = 6;
   localparam int unsigned CAL_CAL_FREQ_SELECT_MSB   = 5;
   localparam int unsigned CAL_CAL_FREQ_SELECT_LSB   = 4;
   localparam int unsigned CAL_ROUTE_MSB  = 3;
   localparam int unsigned CAL_ROUTE_A    = 0;

   // calibration output frequencies in hertz
   localparam int unsigned CAL_F0_HZ      = 1;
   localparam int unsigned CAL_F1_HZ      = 512;
   localparam int unsigned CAL_F2_HZ      = 500;
   localparam int unsigned CAL_F3_HZ      = 16_000;
   // half periods in reference cycles, rounded down
   localparam int unsigned CAL_HALF0      = CLK_HZ / (2 * CAL_F0_HZ);
   localparam int unsigned CAL_HALF1      = CLK_HZ / (2 * CAL_F1_HZ);
   localparam int unsigned CAL_HALF2      = CLK_HZ / (2 * CAL_F2_HZ);
   localparam int unsigned CAL_HALF3      = CLK_HZ / (2 * CAL_F3_HZ);
   localparam int unsigned CAL_CNT_W      = 24;

   // interval timebase codes
   typedef enum logic [1:0] {
      BASE_HTH  = 2'b00,
      BASE_SEC  = 2'b01,
      BASE_MIN  = 2'b10,
      BASE_HOUR = 2'b11
   } rtcia_base_t;

   // interval timer states
   typedef enum logic [1:0] {
      IV_IDLE = 2'b00,
      IV_RUN  = 2'b01,
      IV_HELD = 2'b10
   } rtcia_iv_state_t;

endpackage

// ==== verilog/rtcia_cal_gen.sv ====
// Purpose: square wave source for the calibration output
// Assumes: half periods given in reference clock cycles
// Notes:   the wave restarts low whenever it is disabled or the rate changes
`timescale 1ns/10ps
module rtcia_cal_gen
   import rtcia_pkg::*;
#(
   parameter int unsigned HALF0 = CAL_HALF0,
   parameter int unsigned HALF1 = CAL_HALF1,
   parameter int unsigned HALF2 = CAL_HALF2,
   parameter int unsigned HALF3 = CAL_HALF3
) (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       srst,
   // control
   input  wire logic       enable,
   input  wire logic [1:0] freqSel,
   // wave
   output logic            calWave
);

   logic [CAL_CNT_W-1:0] divCnt_reg;
   logic [CAL_CNT_W-1:0] divCnt_next;
   logic                 wave_reg;
   logic                 wave_next;
   logic [1:0]           selPrev_reg;
   logic [1:0]           selPrev_next;
   logic [CAL_CNT_W-1:0] halfLast;

   // last count of a half period for the chosen rate
   always_comb begin
      case (freqSel)
         2'b00:   halfLast = CAL_CNT_W'(HALF0 - 1);
         2'b01:   halfLast = CAL_CNT_W'(HALF1 - 1);
         2'b10:   halfLast = CAL_CNT_W'(HALF2 - 1);
         default: halfLast = CAL_CNT_W'(HALF3 - 1);
      endcase
   end

   // divider; a rate change restarts it so no runt half period lingers
   always_comb begin
      divCnt_next  = divCnt_reg + 1'b1;
      wave_next    = wave_reg;
      selPrev_next = freqSel;
      if (!enable || freqSel != selPrev_reg) begin
         divCnt_next = '0;
         wave_next   = 1'b0;
      end else if (divCnt_reg >= halfLast) begin
         divCnt_next = '0;
         wave_next   = ~wave_reg;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         divCnt_reg  <= '0;
         wave_reg    <= 1'b0;
         selPrev_reg <= 2'b00;
      end else begin
         divCnt_reg  <= divCnt_next;
         wave_reg    <= wave_next;
         selPrev_reg <= selPrev_next;
      end
   end

   assign calWave = wave_reg;

endmodule // rtcia_cal_gen

// ==== verilog/rtcia_top.sv ====
// Purpose: interval timer, calendar alarm and calibration output of the clock
// Assumes: timekeeping counters and their tick pulses come from outside
// Notes:   indirect registers are reached through pointer and data ports
//
// Functional notes
// - interval counter advances on the selected timebase tick, sets hit flag at target
// - interval counter is eight bits, so at most 256 ticks to the hit (target zero)
// - seconds field joins the alarm match only while its enable bit is set
// - minutes field joins the alarm match only while its enable bit is set
// - hours field joins the alarm match only while its enable bit is set
// - weekday field joins the alarm match only while its enable bit is set
// - date field joins the alarm match only while its enable bit is set
// - alarm hit flag sets only when every enabled field matches at once
// - a raised hit flag with interrupt enabled requests the clock interrupt
// - the output gate bit enables the calibration output on the routed pins
// - two-bit select picks 1 Hz, 512 Hz, 500 Hz or 16 kHz
// - each route bit drives its own pin when the gate is set, outside deepest power mode
// - in deepest power mode only pin a, needing keep bit and gate
// - after a hit the counter restarts, or is held when single shot
// - fast calibration codes clock the timekeeping 125 times faster
// - hit flags stay set until software clears them
`timescale 1ns/10ps
module rtcia_top
   import rtcia_pkg::*;
#(
   parameter int unsigned CNT_W = 8,
   parameter int unsigned HALF0 = CAL_HALF0,
   parameter int unsigned HALF1 = CAL_HALF1,
   parameter int unsigned HALF2 = CAL_HALF2,
   parameter int unsigned HALF3 = CAL_HALF3
) (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       srst,
   // pointer, data and key ports
   input  wire logic       keyWrEn,
   input  wire logic [7:0] keyWrData,
   input  wire logic       ptrWrEn,
   input  wire logic [7:0] ptrWrData,
   output logic [7:0]      ptrRdData,
   input  wire logic       dataWrEn,
   input  wire logic [7:0] dataWrData,
   output logic [7:0]      dataRdData,
   // configuration ports
   input  wire logic       cfg1WrEn,
   input  wire logic [7:0] cfg1WrData,
   output logic [7:0]      cfg1RdData,
   input  wire logic       cfg2WrEn,
   input  wire logic [7:0] cfg2WrData,
   output logic [7:0]      cfg2RdData,
   // live timekeeping
   input  wire logic       tickHth,
   input  wire logic       tickSec,
   input  wire logic       tickMin,
   input  wire logic       tickHour,
   input  wire logic [7:0] liveSecond,
   input  wire logic [7:0] liveMinute,
   input  wire logic [7:0] liveHour,
   input  wire logic [7:0] liveWeekday,
   input  wire logic [7:0] liveDate,
   // power and interrupt
   input  wire logic       deepestPowerMode,
   input  wire logic       clockIrqEnable,
   output logic            clockIrqPending,
   output logic            clockIrqRequest,
   // calibration output
   output logic            fastTimekeep,
   output logic [3:0]      calPinOut
);

   // indirect registers
   logic [7:0] intervalTarget_reg, intervalTarget_next;
   logic [7:0] alSecond_reg, alSecond_next;
   logic [7:0] alMinute_reg, alMinute_next;
   logic [7:0] alHour_reg, alHour_next;
   logic [7:0] alWeekday_reg, alWeekday_next;
   logic [7:0] alDate_reg, alDate_next;
   logic [7:0] calCfg_reg, calCfg_next;
   // pointer port state
   logic [4:0] ptrAddr_reg, ptrAddr_next;
   logic       ptrWrite_reg, ptrWrite_next;
   logic       keyArmed_reg, keyArmed_next;
   logic [7:0] dataRd_reg, dataRd_next;
   // configuration registers
   logic [7:0] cfg1_reg, cfg1_next;
   logic [4:0] cfg2_reg, cfg2_next;
   // interval timer, alarm and calibration pins
   rtcia_iv_state_t  ivState_reg, ivState_next;
   logic [CNT_W-1:0] ivCnt_reg, ivCnt_next;
   logic             alMatchPrev_reg, alMatchPrev_next;
   logic [3:0]       calPin_reg, calPin_next;
   // helpers
   logic             keyedWrite;
   logic             baseTick;
   logic             alarmMatch;
   logic             intervalHit;
   logic             alarmHit;
   logic             calWave;
   logic [CNT_W-1:0] ivCntInc;

   // one field compare, masked out when its enable is clear
   function automatic logic fieldOk(input logic on, input logic [7:0] al,
                                    input logic [7:0] live);
      fieldOk = !on || (al == live);
   endfunction

   // value of an indirect register; unmapped indexes read zero
   function automatic logic [7:0] regRead(input logic [4:0] idx);
      if (idx == IDX_INTERVAL) begin
         regRead = intervalTarget_reg;
      end else if (idx == IDX_AL_SECOND) begin
         regRead = alSecond_reg;
      end else if (idx == IDX_AL_MINUTE) begin
         regRead = alMinute_reg;
      end else if (idx == IDX_ALARM_HOUR_VALUE) begin
         regRead = alHour_reg;
      end else if (idx == IDX_AL_WEEKDAY) begin
         regRead = alWeekday_reg;
      end else if (idx == IDX_ALARM_DATE_VALUE) begin
         regRead = alDate_reg;
      end else if (idx == IDX_CAL_CFG) begin
         regRead = calCfg_reg;
      end else begin
         regRead = RST_BYTE;
      end
   endfunction

   // the key arms only the very next write; any other write disarms it
   assign keyedWrite = dataWrEn && ptrWrite_reg && keyArmed_reg;

   // pointer, key and indirect register writes
   always_comb begin
      ptrAddr_next        = ptrAddr_reg;
      ptrWrite_next       = ptrWrite_reg;
      keyArmed_next       = keyArmed_reg;
      intervalTarget_next = intervalTarget_reg;
      alSecond_next       = alSecond_reg;
      alMinute_next       = alMinute_reg;
      alHour_next         = alHour_reg;
      alWeekday_next      = alWeekday_reg;
      alDate_next         = alDate_reg;
      calCfg_next         = calCfg_reg;
      if (ptrWrEn) begin
         ptrAddr_next  = ptrWrData[PTR_ADDR_MSB:0];
         ptrWrite_next = ptrWrData[PTR_WRITE_BIT];
      end
      if (keyWrEn) begin
         keyArmed_next = (keyWrData == KEY_VALUE);
      end else if (ptrWrEn || dataWrEn || cfg1WrEn || cfg2WrEn) begin
         keyArmed_next = 1'b0;
      end
      if (keyedWrite) begin
         if (ptrAddr_reg == IDX_INTERVAL) begin
            intervalTarget_next = dataWrData;
         end else if (ptrAddr_reg == IDX_AL_SECOND) begin
            alSecond_next = dataWrData;
         end else if (ptrAddr_reg == IDX_AL_MINUTE) begin
            alMinute_next = dataWrData;
         end else if (ptrAddr_reg == IDX_ALARM_HOUR_VALUE) begin
            alHour_next = dataWrData;
         end else if (ptrAddr_reg == IDX_AL_WEEKDAY) begin
            alWeekday_next = dataWrData;
         end else if (ptrAddr_reg == IDX_ALARM_DATE_VALUE) begin
            alDate_next = dataWrData;
         end else if (ptrAddr_reg == IDX_CAL_CFG) begin
            calCfg_next = dataWrData;
         end
      end
      // read-back follows the pointer in the same cycle, register contents one cycle late
      dataRd_next = regRead(ptrAddr_next);
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ptrAddr_reg        <= RST_PTR;
         ptrWrite_reg       <= 1'b0;
         keyArmed_reg       <= 1'b0;
         dataRd_reg         <= RST_BYTE;
         intervalTarget_reg <= RST_BYTE;
         alSecond_reg       <= RST_BYTE;
         alMinute_reg       <= RST_BYTE;
         alHour_reg         <= RST_BYTE;
         alWeekday_reg      <= RST_BYTE;
         alDate_reg         <= RST_BYTE;
         calCfg_reg         <= RST_BYTE;
      end else begin
         ptrAddr_reg        <= ptrAddr_next;
         ptrWrite_reg       <= ptrWrite_next;
         keyArmed_reg       <= keyArmed_next;
         dataRd_reg         <= dataRd_next;
         intervalTarget_reg <= intervalTarget_next;
         alSecond_reg       <= alSecond_next;
         alMinute_reg       <= alMinute_next;
         alHour_reg         <= alHour_next;
         alWeekday_reg      <= alWeekday_next;
         alDate_reg         <= alDate_next;
         calCfg_reg         <= calCfg_next;
      end
   end

   // timebase tick picked by the base select field
   always_comb begin
      case (rtcia_base_t'(cfg1_reg[C1_BASE_MSB:C1_BASE_LSB]))
         BASE_HTH:  baseTick = tickHth;
         BASE_SEC:  baseTick = tickSec;
         BASE_MIN:  baseTick = tickMin;
         default:   baseTick = tickHour;
      endcase
   end

   // eight-bit count wraps, so a target of zero gives the widest span of 256 ticks
   assign ivCntInc = ivCnt_reg + 1'b1;

   // interval timer; a hit happens only on a tick and repeats unless single shot holds it
   always_comb begin
      ivState_next = ivState_reg;
      ivCnt_next   = ivCnt_reg;
      intervalHit  = 1'b0;
      case (ivState_reg)
         IV_IDLE: begin
            ivCnt_next = '0;
            if (cfg1_reg[C1_INT_ENABLE]) begin
               ivState_next = IV_RUN;
            end
         end
         IV_RUN: begin
            if (!cfg1_reg[C1_INT_ENABLE]) begin
               ivState_next = IV_IDLE;
               ivCnt_next   = '0;
            end else if (baseTick) begin
               ivCnt_next = ivCntInc;
               if (ivCntInc == intervalTarget_reg[CNT_W-1:0]) begin
                  intervalHit = 1'b1;
                  ivCnt_next  = '0;
                  if (cfg1_reg[C1_SINGLE_SHOT]) begin
                     ivState_next = IV_HELD;
                  end
               end
            end
         end
         IV_HELD: begin
            ivCnt_next = '0;
            if (!cfg1_reg[C1_INT_ENABLE]) begin
               ivState_next = IV_IDLE;
            end
         end
         default: begin
            ivState_next = IV_IDLE;
            ivCnt_next   = '0;
         end
      endcase
   end

   // all enabled fields must agree; with none enabled there is no alarm
   assign alarmMatch = (|cfg2_reg)
                       && fieldOk(cfg2_reg[C2_SEC_ON], alSecond_reg, liveSecond)
                       && fieldOk(cfg2_reg[C2_MIN_ON], alMinute_reg, liveMinute)
                       && fieldOk(cfg2_reg[C2_HOUR_ON], alHour_reg, liveHour)
                       && fieldOk(cfg2_reg[C2_WDAY_ON], alWeekday_reg, liveWeekday)
                       && fieldOk(cfg2_reg[C2_DATE_ON], alDate_reg, liveDate);
   // edge of the match, so a cleared flag is not set again in the same second
   assign alarmHit         = alarmMatch && !alMatchPrev_reg;
   assign alMatchPrev_next = alarmMatch;

   // configuration registers; hardware set wins over a software clear
   always_comb begin
      cfg1_next = cfg1_reg;
      cfg2_next = cfg2_reg;
      if (cfg1WrEn) begin
         cfg1_next = cfg1WrData;
         // flags can only be cleared by software, writing one keeps them
         cfg1_next[C1_ALARM_HIT] = cfg1_reg[C1_ALARM_HIT] && cfg1WrData[C1_ALARM_HIT];
         cfg1_next[C1_INT_HIT]   = cfg1_reg[C1_INT_HIT] && cfg1WrData[C1_INT_HIT];
      end
      if (cfg2WrEn) begin
         cfg2_next = cfg2WrData[C2_DATE_ON:0];
      end
      if (alarmHit) begin
         cfg1_next[C1_ALARM_HIT] = 1'b1;
      end
      if (intervalHit) begin
         cfg1_next[C1_INT_HIT] = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cfg1_reg        <= RST_BYTE;
         cfg2_reg        <= RST_PTR;
         ivState_reg     <= IV_IDLE;
         ivCnt_reg       <= '0;
         alMatchPrev_reg <= 1'b0;
      end else begin
         cfg1_reg        <= cfg1_next;
         cfg2_reg        <= cfg2_next;
         ivState_reg     <= ivState_next;
         ivCnt_reg       <= ivCnt_next;
         alMatchPrev_reg <= alMatchPrev_next;
      end
   end

   // calibration square wave, only running while the gate is set
   rtcia_cal_gen #(
      .HALF0 (HALF0),
      .HALF1 (HALF1),
      .HALF2 (HALF2),
      .HALF3 (HALF3)
   ) u_cal_gen (
      .ref_clk (ref_clk),
      .srst    (srst),
      .enable  (calCfg_reg[CAL_GATE]),
      .freqSel (calCfg_reg[CAL_CAL_FREQ_SELECT_MSB:CAL_CAL_FREQ_SELECT_LSB]),
      .calWave (calWave)
   );

   // pin routing; deepest power mode leaves only pin a, and only if kept
   always_comb begin
      calPin_next = '0;
      if (calCfg_reg[CAL_GATE] && calWave) begin
         if (deepestPowerMode) begin
            calPin_next[CAL_ROUTE_A] = calCfg_reg[CAL_DEEP_KEEP];
         end else begin
            calPin_next = calCfg_reg[CAL_ROUTE_MSB:CAL_ROUTE_A];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         calPin_reg <= '0;
      end else begin
         calPin_reg <= calPin_next;
      end
   end

   // outputs
   assign calPinOut       = calPin_reg;
   assign fastTimekeep    = calCfg_reg[CAL_CAL_FREQ_SELECT_MSB];
   assign clockIrqPending = cfg1_reg[C1_ALARM_HIT] || cfg1_reg[C1_INT_HIT];
   assign clockIrqRequest = clockIrqPending && clockIrqEnable;
   assign ptrRdData       = {ptrWrite_reg, 2'b00, ptrAddr_reg};
   assign dataRdData      = dataRd_reg;
   assign cfg1RdData      = cfg1_reg;
   assign cfg2RdData      = {3'b000, cfg2_reg};

endmodule // rtcia_top

// ==== sim/rtcia_top_asserts.sv ====
// Purpose: concurrent checks on the interval, alarm and calibration ports
// Assumes: with the pointer on the calibration index, dataRdData shows that register
// Notes:   pin checks wait one cycle because the pins are registered
`timescale 1ns/10ps
module rtcia_top_asserts
   import rtcia_pkg::*;
(
   // clock and reset
   input wire logic       ref_clk,
   input wire logic       srst,
   // register side
   input wire logic       cfg1WrEn,
   input wire logic [7:0] cfg1WrData,
   input wire logic [7:0] cfg1RdData,
   input wire logic [7:0] cfg2RdData,
   input wire logic [7:0] ptrRdData,
   input wire logic [7:0] dataRdData,
   // ticks, power and interrupt
   input wire logic       tickHth,
   input wire logic       tickSec,
   input wire logic       tickMin,
   input wire logic       tickHour,
   input wire logic       deepestPowerMode,
   input wire logic       clockIrqEnable,
   input wire logic       clockIrqPending,
   input wire logic       clockIrqRequest,
   // calibration output
   input wire logic       fastTimekeep,
   input wire logic [3:0] calPinOut
);
   logic       calSel;
   logic [3:0] ticks;
   logic       baseTick;
   // the calibration register is only visible while the pointer selects it
   assign calSel   = ptrRdData[4:0] == IDX_CAL_CFG;
   assign ticks    = {tickHour, tickMin, tickSec, tickHth};
   assign baseTick = ticks[cfg1RdData[5:4]];

   a_irq_request: assert property (@(posedge ref_clk) disable iff (srst)
      clockIrqRequest == (clockIrqPending && clockIrqEnable)) else $error("irq request wrong");
   a_pending_flags: assert property (@(posedge ref_clk) disable iff (srst)
      clockIrqPending == (cfg1RdData[6] || cfg1RdData[2])) else $error("pending wrong");
   a_alarm_hold: assert property (@(posedge ref_clk) disable iff (srst)
      cfg1RdData[6] && !(cfg1WrEn && !cfg1WrData[6]) |=> cfg1RdData[6])
      else $error("alarm flag lost");
   a_iv_hold: assert property (@(posedge ref_clk) disable iff (srst)
      cfg1RdData[2] && !(cfg1WrEn && !cfg1WrData[2]) |=> cfg1RdData[2])
      else $error("interval flag lost");
   a_iv_tick: assert property (@(posedge ref_clk) disable iff (srst)
      $rose(cfg1RdData[2]) |-> $past(baseTick)) else $error("interval hit without tick");
   a_alarm_enabled: assert property (@(posedge ref_clk) disable iff (srst)
      $rose(cfg1RdData[6]) |-> $past(cfg2RdData[4:0]) != 5'h00)
      else $error("alarm hit with no field on");
   a_fast_code: assert property (@(posedge ref_clk) disable iff (srst)
      calSel |-> $past(fastTimekeep) == dataRdData[5]) else $error("fast flag wrong");
   a_pin_route: assert property (@(posedge ref_clk) disable iff (srst)
      (calSel && !deepestPowerMode) ##1 (calSel && !deepestPowerMode && $stable(dataRdData))
      |-> (calPinOut & ~(dataRdData[6] ? dataRdData[3:0] : 4'h0)) == 4'h0)
      else $error("pin driven without route");
   a_pin_deep: assert property (@(posedge ref_clk) disable iff (srst)
      (calSel && deepestPowerMode) ##1 (calSel && deepestPowerMode && $stable(dataRdData))
      |-> calPinOut[3:1] == 3'b000
      && (!calPinOut[0] || (dataRdData[7] && dataRdData[6])))
      else $error("deep mode pin wrong");
endmodule // rtcia_top_asserts

bind rtcia_top rtcia_top_asserts u_chk (
   .ref_clk(ref_clk), .srst(srst), .cfg1WrEn(cfg1WrEn), .cfg1WrData(cfg1WrData),
   .cfg1RdData(cfg1RdData), .cfg2RdData(cfg2RdData), .ptrRdData(ptrRdData),
   .dataRdData(dataRdData), .tickHth(tickHth), .tickSec(tickSec), .tickMin(tickMin),
   .tickHour(tickHour), .deepestPowerMode(deepestPowerMode),
   .clockIrqEnable(clockIrqEnable), .clockIrqPending(clockIrqPending),
   .clockIrqRequest(clockIrqRequest), .fastTimekeep(fastTimekeep), .calPinOut(calPinOut)
);

// ==== sim/rtcia_top_test.sv ====
// Purpose: self-checking bench for the interval timer, alarm and calibration output
// Assumes: short calibration half periods so the wave toggles quickly
// Notes:   all write ports share one data bus driven by the bench
`timescale 1ns/10ps
module rtcia_top_test
   import rtcia_pkg::*;
;
   localparam int H0 = 8, H1 = 4, H2 = 5, H3 = 2;
   localparam int KEY = 0, PTR = 1, DAT = 2, CF1 = 3, CF2 = 4;
   // bench drive
   logic       ref_clk = 0;
   logic       srst = 1;
   logic [4:0] wen = '0;
   logic [7:0] wd = '0;
   logic [3:0] tk = '0;
   logic [7:0] live [5] = '{5{8'h00}};
   logic       deep = 0;
   logic       irqEn = 0;
   // observed
   logic [7:0] ptrRd, dataRd, cfg1Rd, cfg2Rd;
   logic       pend, req, fast;
   logic [3:0] pins, seen;
   // scenario state
   logic [7:0] v, av [5];
   logic [4:0] m;
   int         halfs [4] = '{H0, H1, H2, H3};
   int         n_mismatch = 0, total_checks = 0, cycles = 0, seed = 32'h2abda824;
   int         b, t, n;
   bit         d;

   always #25 ref_clk = ~ref_clk;

   rtcia_top #(.HALF0(H0), .HALF1(H1), .HALF2(H2), .HALF3(H3)) i_dut (
      .ref_clk(ref_clk), .srst(srst), .keyWrEn(wen[KEY]), .keyWrData(wd),
      .ptrWrEn(wen[PTR]), .ptrWrData(wd), .ptrRdData(ptrRd), .dataWrEn(wen[DAT]),
      .dataWrData(wd), .dataRdData(dataRd), .cfg1WrEn(wen[CF1]), .cfg1WrData(wd),
      .cfg1RdData(cfg1Rd), .cfg2WrEn(wen[CF2]), .cfg2WrData(wd), .cfg2RdData(cfg2Rd),
      .tickHth(tk[0]), .tickSec(tk[1]), .tickMin(tk[2]), .tickHour(tk[3]),
      .liveSecond(live[0]), .liveMinute(live[1]), .liveHour(live[2]),
      .liveWeekday(live[3]), .liveDate(live[4]), .deepestPowerMode(deep),
      .clockIrqEnable(irqEn), .clockIrqPending(pend), .clockIrqRequest(req),
      .fastTimekeep(fast), .calPinOut(pins)
   );

   task automatic print_verdict();
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(string what, logic [7:0] got, logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one strobe held for one cycle; a gap cycle follows so no edge sees two writes
   task automatic put(int s, logic [7:0] val);
      @(posedge ref_clk);
      wen <= 5'(1 << s);
      wd  <= val;
      @(posedge ref_clk);
      wen <= '0;
   endtask

   task automatic wreg(logic [4:0] idx, logic [7:0] val, bit keyed);
      put(PTR, {3'b100, idx});
      if (keyed) put(KEY, KEY_VALUE);
      put(DAT, val);
      repeat (2) @(negedge ref_clk);
   endtask

   task automatic pulse(int base);
      @(posedge ref_clk);
      tk <= 4'(1 << base);
      @(posedge ref_clk);
      tk <= '0;
      @(negedge ref_clk);
   endtask

   // a foreign tick follows every counted one but the last and must never advance the count
   task automatic run_iv(int base, int cnt, logic hit);
      for (int i = 1; i < cnt; i++) begin
         pulse(base);
         pulse((base + 1) % 4);
      end
      chk("interval early", {7'b0, cfg1Rd[2]}, 8'h00);
      pulse(base);
      @(negedge ref_clk);
      chk("interval hit", {7'b0, cfg1Rd[2]}, {7'b0, hit});
   endtask

   // hang guard: the whole sequence needs well under this many cycles
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         n_mismatch = n_mismatch + 1;
         print_verdict();
      end
   end

   initial begin
      repeat (20) @(posedge ref_clk);
      srst  <= 0;
      irqEn <= 1'($random(seed));
      // reset values, unmapped places, keyed and unkeyed writes
      for (int i = 8; i <= 16; i++) begin
         put(PTR, 8'(i));
         @(negedge ref_clk);
         chk("reset value", dataRd, 8'h00);
         chk("pointer", ptrRd, 8'(i));
      end
      for (int i = 9; i <= 16; i++) begin
         v = $random(seed);
         wreg(5'(i), v, 1);
         chk("keyed write", dataRd, (i == 16) ? 8'h00 : v);
         wreg(5'(i), ~v, 0);
         chk("unkeyed write", dataRd, (i == 16) ? 8'h00 : v);
      end
      // interval timer: restart, single shot, then the full 8-bit span
      b = $unsigned($random(seed)) % 4;
      t = $unsigned($random(seed)) % 6 + 1;
      wreg(IDX_INTERVAL, 8'(t), 1);
      put(CF1, {2'b00, 2'(b), 4'b0010});
      repeat (2) @(posedge ref_clk);
      run_iv(b, t, 1);
      chk("irq pending", {7'b0, pend}, 8'h01);
      chk("irq request", {7'b0, req}, {7'b0, irqEn});
      put(CF1, {2'b00, 2'(b), 4'b0010});
      run_iv(b, t, 1);
      put(CF1, {2'b00, 2'(b), 4'b1010});
      run_iv(b, t, 1);
      put(CF1, {2'b00, 2'(b), 4'b1010});
      run_iv(b, t, 0);
      put(CF1, 8'h00);
      wreg(IDX_INTERVAL, 8'h00, 1);
      put(CF1, {2'b00, 2'(b), 4'b0010});
      repeat (2) @(posedge ref_clk);
      run_iv(b, 256, 1);
      put(CF1, 8'h00);
      // alarm: field f disagrees first, disabled fields always disagree
      for (int f = 0; f < 5; f++) begin
         put(CF2, 8'h00);
         for (int i = 0; i < 5; i++) begin
            av[i] = $random(seed);
            wreg(5'(IDX_AL_SECOND + i), av[i], 1);
         end
         m = 5'($random(seed)) | 5'(1 << f);
         @(posedge ref_clk);
         for (int i = 0; i < 5; i++) live[i] <= (m[i] && i != f) ? av[i] : ~av[i];
         put(CF2, {3'b000, m});
         repeat (3) @(negedge ref_clk);
         chk("alarm mismatch", {7'b0, cfg1Rd[6]}, 8'h00);
         chk("enables", cfg2Rd, {3'b000, m});
         @(posedge ref_clk);
         live[f] <= av[f];
         repeat (3) @(negedge ref_clk);
         chk("alarm match", {7'b0, cfg1Rd[6]}, 8'h01);
         put(CF1, 8'h00);
         repeat (3) @(negedge ref_clk);
         chk("alarm once", {7'b0, cfg1Rd[6]}, 8'h00);
      end
      // calibration rates, measured as high time of pin a
      for (int fs = 0; fs < 4; fs++) begin
         wreg(IDX_CAL_CFG, {2'b01, 2'(fs), 4'b0001}, 1);
         chk("fast timekeeping", {7'b0, fast}, {7'b0, fs[1]});
         n = 0;
         while (pins[0] !== 1'b0) @(negedge ref_clk);
         while (pins[0] !== 1'b1 && n < 100) begin
            @(negedge ref_clk);
            n++;
         end
         n = 0;
         while (pins[0] === 1'b1 && n < 100) begin
            @(negedge ref_clk);
            n++;
         end
         chk("half period", 8'(n), 8'(halfs[fs]));
      end
      // random routing, gate, keep bit and power mode at the fast rate
      for (int k = 0; k < 16; k++) begin
         v = $random(seed);
         v[5:4] = 2'b11;
         d = $random(seed);
         @(posedge ref_clk);
         deep <= d;
         wreg(IDX_CAL_CFG, v, 1);
         repeat (2) @(negedge ref_clk);
         seen = '0;
         repeat (8) begin
            @(negedge ref_clk);
            seen |= pins;
         end
         chk("pins", {4'h0, seen}, {4'h0, d ? {3'b000, v[7] & v[6]}
            : (v[6] ? v[3:0] : 4'h0)});
      end
      print_verdict();
   end
endmodule // rtcia_top_test
